//--- hdl/sle_cfg.svh
// constants for the serial link example top and its partner end
`ifndef SLE_CFG_SVH
`define SLE_CFG_SVH
`define SLE_WORD_W      16
`define SLE_CNT_W       8
`define SLE_CNT_MAX     8'hFF
`define SLE_CNT_ONE     8'h01
`define SLE_LANES       1
`define SLE_SB_W        4
`define SLE_DEB_LEN     4
`define SLE_LFSR_SEED   16'hACE1
`define SLE_LFSR_TAPS   16'hB400
`define SLE_ERR_FLIP    16'h0001
`define SLE_TRAIN_CYC   8'h10
`define SLE_BOND_CYC    8'h04
`define SLE_DBG_W       16
`endif

//--- hdl/sle_pkg.sv
// types and shared functions of the serial link example top
`include "sle_cfg.svh"
package sle_pkg;
    typedef logic [`SLE_WORD_W-1:0] sle_word_type;
    typedef enum {SLE_DUPLEX, SLE_TX_ONLY, SLE_RX_ONLY} sle_build_type;
    typedef enum {SLE_ST_IDLE, SLE_ST_TRAIN, SLE_ST_BOND, SLE_ST_UP}
        sle_state_type;

    // both ends must walk the same sequence from the same seed
    function automatic sle_word_type sle_lfsr_next(input sle_word_type v);
        sle_word_type taps;
        taps = `SLE_LFSR_TAPS;
        return {v[`SLE_WORD_W-2:0], ^(v & taps)};
    endfunction : sle_lfsr_next
endpackage : sle_pkg

//--- hdl/sle_link_if.sv
// link between the partner core end and the example top end
`timescale 1ns/1ps
`include "sle_cfg.svh"
interface sle_link_if;
    logic                   xcvr_rst;
    logic [`SLE_WORD_W-1:0] rx_data;
    logic                   rx_valid;
    logic                   rx_ready;
    logic [`SLE_LANES-1:0]  lane_up;
    logic                   channel_up;
    logic                   hard_err;
    logic                   soft_err;
    logic                   frame_err;
    logic [`SLE_SB_W-1:0]   sb_to_core;
    logic [`SLE_SB_W-1:0]   sb_from_core;

    modport partner_mp (
        input  xcvr_rst, rx_ready, sb_to_core,
        output rx_data, rx_valid, lane_up, channel_up,
        output hard_err, soft_err, frame_err, sb_from_core
    );
    modport device_mp (
        output xcvr_rst, rx_ready, sb_to_core,
        input  rx_data, rx_valid, lane_up, channel_up,
        input  hard_err, soft_err, frame_err, sb_from_core
    );
endinterface : sle_link_if

//--- hdl/sle_partner.sv
// partner core end: trains the link and sends the lfsr word stream
`timescale 1ns/1ps
`include "sle_cfg.svh"
module sle_partner (
    // clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       sys_rst_in,
    // user side
    input  wire logic       gen_enable_in,
    input  wire logic       inject_error_in,
    input  wire logic       hard_err_in,
    input  wire logic       soft_err_in,
    input  wire logic       frame_err_in,
    output logic            link_up_out,
    // link side
    sle_link_if.partner_mp  link
);
    sle_pkg::sle_state_type state;
    sle_pkg::sle_word_type  lfsr;
    logic [7:0]             timer;
    logic [1:0]             en_sync;
    logic [1:0]             inj_sync;
    logic [2:0]             err_s1;
    logic [2:0]             err_s2;
    logic                   send;

    always_ff @(posedge ref_clk_in)
    begin
        en_sync  <= {en_sync[0], gen_enable_in};
        inj_sync <= {inj_sync[0], inject_error_in};
        err_s1   <= {hard_err_in, soft_err_in, frame_err_in};
        err_s2   <= err_s1;
    end

    // training walk; a transceiver reset from the top restarts it
    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in || link.xcvr_rst)
        begin
            state <= sle_pkg::SLE_ST_IDLE;
            timer <= '0;
        end
        else
        begin
            case (state)
                sle_pkg::SLE_ST_IDLE:
                begin
                    state <= sle_pkg::SLE_ST_TRAIN;
                    timer <= `SLE_TRAIN_CYC;
                end
                sle_pkg::SLE_ST_TRAIN:
                begin
                    timer <= timer - 8'h01;
                    if (timer == 8'h01)
                    begin
                        state <= sle_pkg::SLE_ST_BOND;
                        timer <= `SLE_BOND_CYC;
                    end
                end
                sle_pkg::SLE_ST_BOND:
                begin
                    timer <= timer - 8'h01;
                    if (timer == 8'h01)
                        state <= sle_pkg::SLE_ST_UP;
                end
                sle_pkg::SLE_ST_UP:
                    state <= sle_pkg::SLE_ST_UP;
                default:
                    state <= sle_pkg::SLE_ST_IDLE;
            endcase
        end
    end

    assign send = (state == sle_pkg::SLE_ST_UP) && en_sync[1];

    // looped word stream, held while the top stalls
    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in || link.xcvr_rst)
        begin
            lfsr         <= `SLE_LFSR_SEED;
            link.rx_data <= '0;
            link.rx_valid <= 1'b0;
        end
        else if (!link.rx_valid || link.rx_ready)
        begin
            link.rx_valid <= send;
            if (send)
            begin
                link.rx_data <= inj_sync[1] ? (lfsr ^ `SLE_ERR_FLIP) : lfsr;
                lfsr         <= sle_pkg::sle_lfsr_next(lfsr);
            end
        end
    end

    // status and sideband sent back; the sideband echoes what the top sends
    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            link.lane_up      <= '0;
            link.channel_up   <= 1'b0;
            link.hard_err     <= 1'b0;
            link.soft_err     <= 1'b0;
            link.frame_err    <= 1'b0;
            link.sb_from_core <= '0;
        end
        else
        begin
            link.lane_up      <= {`SLE_LANES{state == sle_pkg::SLE_ST_BOND ||
                                             state == sle_pkg::SLE_ST_UP}};
            link.channel_up   <= (state == sle_pkg::SLE_ST_UP);
            link.hard_err     <= err_s2[2];
            link.soft_err     <= err_s2[1];
            link.frame_err    <= err_s2[0];
            link.sb_from_core <= link.sb_to_core;
        end
    end

    assign link_up_out = link.channel_up;
endmodule : sle_partner

//--- hdl/sle_top.sv
// example top end: reset debounce, status registers, frame checker
//
// Behaviour
// - count mismatched received words, eight bits
// - debounce system reset on user clock
// - debounce transceiver reset before core
// - register core error flags before output
// - one channel ready, or per direction
// - lane ready per transceiver, one or per direction
// - register simplex sideband signals both ways
// - bench waits channel ready, then checks
// - bench reports error on bad data
// - duplex bench loops transmit to receive
// - simplex bench pairs transmit and receive
// - debug cores included when parameter one
`timescale 1ns/1ps
`include "sle_cfg.svh"
module sle_top #(
    parameter sle_pkg::sle_build_type BUILD = sle_pkg::SLE_DUPLEX,
    parameter bit debug_cores_include      = 1'b0
) (
    // clock and resets
    input  wire logic                    ref_clk_in,
    input  wire logic                    sys_rst_in,
    input  wire logic                    transceiver_reset_in,
    // user side controls
    input  wire logic                    check_hold_in,
    input  wire logic [`SLE_SB_W-1:0]    sideband_in,
    // status outputs
    output logic [`SLE_CNT_W-1:0]        err_count_out,
    output logic                         mismatch_out,
    output logic                         hard_err_out,
    output logic                         soft_err_out,
    output logic                         frame_err_out,
    output logic                         channel_ready_out,
    output logic                         tx_channel_ready_out,
    output logic                         rx_channel_ready_out,
    output logic [`SLE_LANES-1:0]        lane_ready_out,
    output logic [`SLE_LANES-1:0]        tx_lane_ready_out,
    output logic [`SLE_LANES-1:0]        rx_lane_ready_out,
    output logic [`SLE_SB_W-1:0]         sideband_out,
    output logic [`SLE_DBG_W-1:0]        debug_probe_out,
    // link side
    sle_link_if.device_mp                link
);
    localparam bit SIMPLEX = (BUILD != sle_pkg::SLE_DUPLEX);
    localparam bit HAS_TX  = (BUILD != sle_pkg::SLE_RX_ONLY);
    localparam bit HAS_RX  = (BUILD != sle_pkg::SLE_TX_ONLY);

    logic [1:0]                 rst_sync;
    logic [1:0]                 xrst_sync;
    logic [`SLE_DEB_LEN-1:0]    rst_shift;
    logic [`SLE_DEB_LEN-1:0]    xrst_shift;
    logic                       rst;
    logic                       xrst;

    sle_pkg::sle_word_type      buf_data [0:1];
    logic [1:0]                 buf_count;
    logic                       buf_wr;
    logic                       buf_rd;
    logic                       in_ready;
    logic                       out_valid;
    logic                       out_ready;
    logic                       push;
    logic                       pop;

    sle_pkg::sle_word_type      expected;
    logic                       mismatch;
    logic [`SLE_SB_W-1:0]       sb_in_reg;

    // debounced level: follows the input only after it stays put
    function automatic logic debounce_next(
        input logic                    cur,
        input logic [`SLE_DEB_LEN-1:0] shift
    );
        if (&shift)
            return 1'b1;
        else if (~|shift)
            return 1'b0;
        else
            return cur;
    endfunction : debounce_next

    always_ff @(posedge ref_clk_in)
    begin
        rst_sync  <= {rst_sync[0], sys_rst_in};
        rst_shift <= {rst_shift[`SLE_DEB_LEN-2:0], rst_sync[1]};
        rst       <= debounce_next(rst, rst_shift);
    end

    // transceiver reset debounce, also forced by system reset
    always_ff @(posedge ref_clk_in)
    begin
        xrst_sync  <= {xrst_sync[0], transceiver_reset_in};
        xrst_shift <= {xrst_shift[`SLE_DEB_LEN-2:0], xrst_sync[1]};
        xrst       <= debounce_next(xrst, xrst_shift);
    end

    assign link.xcvr_rst = xrst || rst;

    // two-entry buffer between link and checker; a held checker
    // pushes back on the link instead of dropping words
    assign in_ready     = (buf_count != 2'h2);
    assign out_valid    = (buf_count != 2'h0);
    assign out_ready    = !check_hold_in;
    assign push         = link.rx_valid && in_ready && HAS_RX;
    assign pop          = out_valid && out_ready;
    assign link.rx_ready = in_ready && HAS_RX;

    always_ff @(posedge ref_clk_in)
    begin
        if (rst || link.xcvr_rst)
        begin
            buf_count <= 2'h0;
            buf_wr    <= 1'b0;
            buf_rd    <= 1'b0;
        end
        else
        begin
            if (push)
                buf_wr <= !buf_wr;
            if (pop)
                buf_rd <= !buf_rd;
            if (push && !pop)
                buf_count <= buf_count + 2'h1;
            else if (pop && !push)
                buf_count <= buf_count - 2'h1;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (push)
            buf_data[buf_wr] <= link.rx_data;
    end

    // frame checker: own copy of the generator sequence
    assign mismatch = pop && (buf_data[buf_rd] != expected);

    always_ff @(posedge ref_clk_in)
    begin
        if (rst || link.xcvr_rst)
            expected <= `SLE_LFSR_SEED;
        else if (pop)
            expected <= sle_pkg::sle_lfsr_next(expected);
    end

    // mismatch tally in the user clock domain
    always_ff @(posedge ref_clk_in)
    begin
        if (rst)
        begin
            err_count_out <= '0;
            mismatch_out  <= 1'b0;
        end
        else
        begin
            mismatch_out <= mismatch;
            if (mismatch && err_count_out != `SLE_CNT_MAX)
                err_count_out <= err_count_out + `SLE_CNT_ONE;
        end
    end

    // error flags registered before the pins
    always_ff @(posedge ref_clk_in)
    begin
        if (rst)
        begin
            hard_err_out  <= 1'b0;
            soft_err_out  <= 1'b0;
            frame_err_out <= 1'b0;
        end
        else
        begin
            hard_err_out  <= link.hard_err;
            soft_err_out  <= link.soft_err;
            frame_err_out <= link.frame_err;
        end
    end

    // channel ready, single or per supported direction
    always_ff @(posedge ref_clk_in)
    begin
        if (rst)
        begin
            channel_ready_out    <= 1'b0;
            tx_channel_ready_out <= 1'b0;
            rx_channel_ready_out <= 1'b0;
        end
        else
        begin
            channel_ready_out    <= !SIMPLEX && link.channel_up;
            tx_channel_ready_out <= SIMPLEX && HAS_TX && link.channel_up;
            rx_channel_ready_out <= SIMPLEX && HAS_RX && link.channel_up;
        end
    end

    // lane ready per transceiver, single or split by supported direction
    genvar g;
    generate
        for (g = 0; g < `SLE_LANES; g = g + 1)
        begin : g_lane
            always_ff @(posedge ref_clk_in)
            begin
                if (rst)
                begin
                    lane_ready_out[g]    <= 1'b0;
                    tx_lane_ready_out[g] <= 1'b0;
                    rx_lane_ready_out[g] <= 1'b0;
                end
                else
                begin
                    lane_ready_out[g]    <= !SIMPLEX && link.lane_up[g];
                    tx_lane_ready_out[g] <= SIMPLEX && HAS_TX &&
                                            link.lane_up[g];
                    rx_lane_ready_out[g] <= SIMPLEX && HAS_RX &&
                                            link.lane_up[g];
                end
            end
        end
    endgenerate

    // simplex sideband registered in both directions
    always_ff @(posedge ref_clk_in)
    begin
        if (rst || !SIMPLEX)
        begin
            sb_in_reg    <= '0;
            sideband_out <= '0;
        end
        else
        begin
            sb_in_reg    <= sideband_in;
            sideband_out <= link.sb_from_core;
        end
    end

    assign link.sb_to_core = sb_in_reg;

    // probe capture stands in for the debug cores
    generate
        if (debug_cores_include == 1'b1)
        begin : g_debug
            always_ff @(posedge ref_clk_in)
            begin
                if (rst)
                    debug_probe_out <= '0;
                else
                    debug_probe_out <= {err_count_out, buf_count,
                                        link.channel_up, link.hard_err,
                                        link.soft_err, link.frame_err,
                                        out_valid, mismatch};
            end
        end
        else
        begin : g_no_debug
            assign debug_probe_out = '0;
        end
    endgenerate
endmodule : sle_top

//--- bench/sle_top_monitor.sv
// concurrent checks on the link and the status outputs of the example top
`timescale 1ns/1ps
`include "sle_cfg.svh"
module sle_top_monitor (
    // clock and resets
    input wire logic                   ref_clk_in,
    input wire logic                   sys_rst_in,
    input wire logic                   transceiver_reset_in,
    // link signals
    input wire logic                   xcvr_rst,
    input wire logic [`SLE_WORD_W-1:0] rx_data,
    input wire logic                   rx_valid,
    input wire logic                   rx_ready,
    input wire logic [`SLE_LANES-1:0]  lane_up,
    input wire logic                   channel_up,
    input wire logic                   hard_err,
    input wire logic                   soft_err,
    input wire logic                   frame_err,
    // top status outputs
    input wire logic [`SLE_CNT_W-1:0]  err_count_out,
    input wire logic                   mismatch_out,
    input wire logic                   hard_err_out,
    input wire logic                   soft_err_out,
    input wire logic                   frame_err_out,
    input wire logic                   channel_ready_out,
    input wire logic [`SLE_LANES-1:0]  lane_ready_out
);
    // initialised so the counts are known before the first reset lands
    logic [3:0] hi_cnt = 4'h0;
    logic [3:0] lo_cnt = 4'h0;
    // status registers hold unknowns until the debounced reset has
    // first landed, so the checks after the two reset checks stay off until then
    logic       armed  = 1'b0;

    default clocking mon_cb @(posedge ref_clk_in);
    endclocking

    always_ff @(posedge ref_clk_in)
    begin
        if (xcvr_rst)
            armed <= 1'b1;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in || transceiver_reset_in)
        begin
            lo_cnt <= 4'h0;
            if (hi_cnt != 4'hF) hi_cnt <= hi_cnt + 4'h1;
        end
        else
        begin
            hi_cnt <= 4'h0;
            if (lo_cnt != 4'hF) lo_cnt <= lo_cnt + 4'h1;
        end
    end

    // the reset itself is under test here, so nothing disables these two
    a_reset_reaches_core: assert property (
        disable iff (1'b0) hi_cnt >= 4'h9 |-> xcvr_rst)
        else $error("core reset missing after long reset input");
    a_reset_releases: assert property (
        disable iff (1'b0) lo_cnt >= 4'hA |-> !xcvr_rst)
        else $error("core reset stuck after reset inputs low");
    a_tally_steps_up: assert property (
        disable iff (xcvr_rst || !armed)
        mismatch_out |-> err_count_out == (($past(err_count_out) == 8'hFF)
            ? 8'hFF : $past(err_count_out) + 8'h01))
        else $error("tally did not step on a mismatch");
    a_tally_holds: assert property (
        disable iff (xcvr_rst || !armed)
        !mismatch_out |-> $stable(err_count_out))
        else $error("tally moved without a mismatch");
    a_tally_saturates: assert property (
        disable iff (xcvr_rst || !armed)
        $past(err_count_out) == 8'hFF |-> err_count_out == 8'hFF)
        else $error("tally wrapped past its maximum");
    a_flags_registered: assert property (
        disable iff (xcvr_rst || !armed)
        {hard_err_out, soft_err_out, frame_err_out}
            == $past({hard_err, soft_err, frame_err}))
        else $error("error flags not one register behind the link");
    a_channel_registered: assert property (
        disable iff (xcvr_rst || !armed)
        channel_up ##1 channel_up |-> channel_ready_out ##1 channel_ready_out)
        else $error("channel ready does not follow the link");
    a_lane_registered: assert property (
        disable iff (xcvr_rst || !armed)
        lane_ready_out == $past(lane_up))
        else $error("lane ready not one register behind the link");
    a_stream_holds: assert property (
        disable iff (xcvr_rst || !armed)
        rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
        else $error("refused word changed before it was taken");
endmodule : sle_top_monitor

//--- bench/tb_serial_link_example_top.sv
// self-checking bench: partner end and example top end joined by the link
`timescale 1ns/1ps
`include "sle_cfg.svh"
module tb_serial_link_example_top;
    typedef struct packed {
        logic [2:0] flags;
        logic [3:0] sb;
        logic [2:0] exp_flags;
        logic [3:0] exp_sb;
    } sle_row_type;
    localparam int CEIL = 5000;
    logic                   ref_clk_in, sys_rst_in, transceiver_reset_in;
    logic                   check_hold_in, gen_enable_in, inject_error_in;
    logic                   hard_err_in, soft_err_in, frame_err_in;
    logic [`SLE_SB_W-1:0]   sideband_in, sideband_out;
    logic [`SLE_CNT_W-1:0]  err_count_out;
    logic                   mismatch_out, hard_err_out, soft_err_out;
    logic                   frame_err_out, link_up_out, channel_ready_out;
    logic                   tx_channel_ready_out, rx_channel_ready_out;
    logic [`SLE_LANES-1:0]  lane_ready_out, tx_lane_ready_out;
    logic [`SLE_LANES-1:0]  rx_lane_ready_out;
    logic [`SLE_DBG_W-1:0]  debug_probe_out;
    // simplex pair: {tx link up, ready, tx ready, rx ready, lane,
    // tx lane, rx lane}, then its sideband and tally
    logic [6:0]             sx_rdy;
    logic [`SLE_SB_W-1:0]   sx_sb;
    logic [`SLE_CNT_W-1:0]  sx_cnt;
    int                     fail_count = 0;
    int                     comparisons = 0;
    int                     cycles = 0;
    // expected columns are duplex outputs: the sideband stays quiet in this build; the simplex sideband echoes sb
    sle_row_type rows [5] = '{'{3'b100, 4'hA, 3'b100, 4'h0},
        '{3'b010, 4'h5, 3'b010, 4'h0}, '{3'b001, 4'hF, 3'b001, 4'h0},
        '{3'b111, 4'h1, 3'b111, 4'h0}, '{3'b000, 4'h0, 3'b000, 4'h0}};

    sle_link_if i_sle_link_if ();
    // the two ends face each other across one link
    sle_partner i_sle_partner (.ref_clk_in, .sys_rst_in, .gen_enable_in,
        .inject_error_in, .hard_err_in, .soft_err_in, .frame_err_in,
        .link_up_out, .link(i_sle_link_if));
    sle_top #(.debug_cores_include(1'b1)) i_sle_top (.ref_clk_in,
        .sys_rst_in, .transceiver_reset_in, .check_hold_in, .sideband_in,
        .err_count_out, .mismatch_out, .hard_err_out, .soft_err_out,
        .frame_err_out, .channel_ready_out, .tx_channel_ready_out,
        .rx_channel_ready_out, .lane_ready_out, .tx_lane_ready_out,
        .rx_lane_ready_out, .sideband_out, .debug_probe_out,
        .link(i_sle_link_if));
    sle_link_if i_sle_link_if_sx ();
    // the partner only transmits into a receive-only build
    sle_partner i_sle_partner_sx (.ref_clk_in, .sys_rst_in, .gen_enable_in,
        .inject_error_in, .hard_err_in, .soft_err_in, .frame_err_in,
        .link_up_out(sx_rdy[6]), .link(i_sle_link_if_sx));
    sle_top #(.BUILD(sle_pkg::SLE_RX_ONLY)) i_sle_top_rx (.ref_clk_in,
        .sys_rst_in, .transceiver_reset_in, .check_hold_in, .sideband_in,
        .err_count_out(sx_cnt), .mismatch_out(), .hard_err_out(),
        .soft_err_out(), .frame_err_out(), .channel_ready_out(sx_rdy[5]),
        .tx_channel_ready_out(sx_rdy[4]), .rx_channel_ready_out(sx_rdy[3]),
        .lane_ready_out(sx_rdy[2]), .tx_lane_ready_out(sx_rdy[1]),
        .rx_lane_ready_out(sx_rdy[0]), .sideband_out(sx_sb),
        .debug_probe_out(), .link(i_sle_link_if_sx));
    sle_top_monitor i_sle_top_monitor (.ref_clk_in, .sys_rst_in,
        .transceiver_reset_in, .xcvr_rst(i_sle_link_if.xcvr_rst),
        .rx_data(i_sle_link_if.rx_data), .rx_valid(i_sle_link_if.rx_valid),
        .rx_ready(i_sle_link_if.rx_ready), .lane_up(i_sle_link_if.lane_up),
        .channel_up(i_sle_link_if.channel_up),
        .hard_err(i_sle_link_if.hard_err), .soft_err(i_sle_link_if.soft_err),
        .frame_err(i_sle_link_if.frame_err), .err_count_out, .mismatch_out,
        .hard_err_out, .soft_err_out, .frame_err_out, .channel_ready_out,
        .lane_ready_out);

    initial
    begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    always @(posedge ref_clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == CEIL)
        begin
            fail_count++;
            $display("ERROR at %0t: run took too long", $time);
            conclude();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic ticks(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask : ticks

    task automatic settle(input int n);
        ticks(n);
        @(negedge ref_clk_in);
    endtask : settle

    task automatic wait_up();
        int n;
        n = 0;
        while (channel_ready_out !== 1'b1 && n < 400)
        begin
            @(negedge ref_clk_in);
            n++;
        end
        chk(16'(channel_ready_out), 16'h0001);
    endtask : wait_up

    initial
    begin
        sys_rst_in = 1'b1;
        transceiver_reset_in = 1'b0;
        check_hold_in = 1'b0;
        sideband_in = 4'h0;
        gen_enable_in = 1'b0;
        inject_error_in = 1'b0;
        {hard_err_in, soft_err_in, frame_err_in} = 3'b000;
        // the debounce needs more than six edges to pass the reset on
        settle(12);
        chk(16'(err_count_out), 16'h0000);
        chk(16'(i_sle_link_if.xcvr_rst), 16'h0001);
        @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        gen_enable_in <= 1'b1;
        wait_up();
        chk(16'(link_up_out), 16'h0001);
        chk(16'(sx_rdy), 16'h0049);
        chk(16'(lane_ready_out), 16'h0001);
        chk(16'({tx_channel_ready_out, rx_channel_ready_out}), 16'h0);
        chk(16'({tx_lane_ready_out, rx_lane_ready_out}), 16'h0000);
        $display("test bring-up done");
        foreach (rows[i])
        begin
            @(posedge ref_clk_in);
            {hard_err_in, soft_err_in, frame_err_in} <= rows[i].flags;
            sideband_in <= rows[i].sb;
            settle(8);
            chk(16'({hard_err_out, soft_err_out, frame_err_out}),
                16'(rows[i].exp_flags));
            chk(16'(sideband_out), 16'(rows[i].exp_sb));
            chk(16'(sx_sb), 16'(rows[i].sb));
        end
        $display("test status rows done");
        wait_up();
        settle(50);
        chk(16'(err_count_out), 16'h0000);
        chk(16'(sx_cnt), 16'h0000);
        @(posedge ref_clk_in);
        check_hold_in <= 1'b1;
        settle(10);
        chk(16'(i_sle_link_if.rx_ready), 16'h0000);
        @(posedge ref_clk_in);
        check_hold_in <= 1'b0;
        settle(20);
        chk(16'(err_count_out), 16'h0000);
        $display("test stall done");
        @(posedge ref_clk_in);
        inject_error_in <= 1'b1;
        ticks(10);
        inject_error_in <= 1'b0;
        settle(20);
        chk(16'(err_count_out), 16'h000A);
        chk(16'(debug_probe_out[15:8]), 16'h000A);
        chk(16'(sx_cnt), 16'h000A);
        @(posedge ref_clk_in);
        inject_error_in <= 1'b1;
        ticks(299);
        @(negedge ref_clk_in);
        chk(16'(mismatch_out), 16'h0001);
        @(posedge ref_clk_in);
        inject_error_in <= 1'b0;
        settle(20);
        chk(16'(err_count_out), 16'h00FF);
        $display("test tally done");
        @(posedge ref_clk_in);
        transceiver_reset_in <= 1'b1;
        ticks(2);
        transceiver_reset_in <= 1'b0;
        settle(10);
        chk(16'(channel_ready_out), 16'h0001);
        @(posedge ref_clk_in);
        transceiver_reset_in <= 1'b1;
        settle(12);
        chk(16'(i_sle_link_if.xcvr_rst), 16'h0001);
        chk(16'(channel_ready_out), 16'h0000);
        chk(16'(err_count_out), 16'h00FF);
        @(posedge ref_clk_in);
        transceiver_reset_in <= 1'b0;
        wait_up();
        $display("test transceiver reset done");
        @(posedge ref_clk_in);
        sys_rst_in <= 1'b1;
        settle(12);
        chk(16'(err_count_out), 16'h0000);
        chk(16'(channel_ready_out), 16'h0000);
        @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        wait_up();
        settle(30);
        chk(16'(err_count_out), 16'h0000);
        $display("test system reset done");
        conclude();
    end
endmodule : tb_serial_link_example_top
